// >>> shared/apc_pkg.sv
// Shared constants and types for the parallel conversion-control block
package apc_pkg;
   // Result and bus widths
   localparam int RES_W         = 12;
   localparam int CHAN_W        = 3;
   localparam int BYTE_W        = 8;
   localparam int NIB_W         = 4;
   // Conversion timing: master clock edges, then tail delay
   localparam int CONV_EDGES    = 13;
   localparam int TAIL_DELAY_NS = 20;
   localparam int CLK_PERIOD_NS = 20;
   localparam int TAIL_CYCLES   = (TAIL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                  (TAIL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 4;
   // Reset values
   localparam logic [RES_W-1:0]  RESULT_RST = 12'h000;
   localparam logic [RES_W-1:0]  WREG_RST   = 12'h000;
   localparam logic [CHAN_W-1:0] CHAN_RST   = 3'h0;
   // Conversion states
   typedef enum logic [1:0] {
      ST_TRACK,
      ST_CONVERT,
      ST_TAIL
   } apc_state_t;
endpackage

// >>> rtl/apc_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module apc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // First stage is read only by the second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// >>> rtl/apc_ctrl.sv
// Conversion control and parallel host port of a 12-bit converter
`timescale 1ns/1ps
// Behaviour
// [R1] Upper data lines three-state, gated by strobes
// [R2] Busy rises after start strobe falls
// [R3] Busy falls once result is loaded
// [R4] Track mode on thirteenth master clock edge
// [R5] Thirteen master edges plus tail delay
// [R6] Works with continuous or burst master clock
// [R7] Start falling edge enters hold, starts conversion
// [R8] Start rising edge wakes from power-down
// [R9] Write strobe with select captures bus data
// [R10] Result driven after read strobe falls
// [R11] Strobes ignored without active chip select
// [R12] Byte mode: high byte enable picks half
// [R13] High byte read carries channel identifier
// [R14] Host drives high-byte bits 4-7 zero
// [R15] Word/byte select picks transfer width
// [R16] Bus released unless select and read low
module apc_ctrl
   import apc_pkg::*;
#(
   parameter int CONV_N = CONV_EDGES
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   // Conversion pins
   input  wire logic              master_conv_clock,
   input  wire logic              conversion_start_n,
   output logic                   busy,
   output logic                   track_mode,
   // Host strobes
   input  wire logic              cs_n,
   input  wire logic              rd_n,
   input  wire logic              wr_n,
   input  wire logic              word_mode,
   // Data bus: bit 8 doubles as high_byte_select in byte mode
   input  wire logic [RES_W-1:0]  data_in,
   output logic      [RES_W-1:0]  data_out,
   output logic      [RES_W-1:0]  data_oe,
   // Converter core side
   input  wire logic [RES_W-1:0]  sar_result,
   input  wire logic [CHAN_W-1:0] sar_channel,
   input  wire logic              low_power_mode,
   output logic                   power_up,
   output logic      [RES_W-1:0]  wr_data,
   output logic                   wr_strobe,
   output logic                   wr_high_byte
);
   localparam int HBS_BIT = BYTE_W;
   localparam int NPIN    = 8 + RES_W;

   typedef struct packed {
      apc_state_t        st;
      logic [CNT_W-1:0]  edges;
      logic [CNT_W-1:0]  tail;
      logic              mclk_prev;
      logic              cst_prev;
      logic              rd_prev;
      logic              wr_prev;
      logic              busy;
      logic              track;
      logic              pwr;
      logic [RES_W-1:0]  result;
      logic [CHAN_W-1:0] chan;
      logic [RES_W-1:0]  dout;
      logic [RES_W-1:0]  oe;
      logic [RES_W-1:0]  wdata;
      logic              wstb;
      logic              whigh;
   } apc_regs_t;

   apc_regs_t r_q;
   apc_regs_t r_d;

   logic [NPIN-1:0] pins_raw;
   logic [NPIN-1:0] pins_s;
   logic            mclk_s;
   logic            cst_s;
   logic            cs_s;
   logic            rd_s;
   logic            wr_s;
   logic            wm_s;
   logic [RES_W-1:0] din_s;

   // All pins cross into clk through two flops; active-low strobes are
   // inverted first so a cleared synchroniser reads as idle, not as a read
   assign pins_raw = {master_conv_clock, ~conversion_start_n, ~cs_n, ~rd_n, ~wr_n,
                      word_mode, 2'b00, data_in};

   apc_sync #(
      .W (NPIN)
   ) u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      (pins_raw),
      .q      (pins_s)
   );

   assign mclk_s = pins_s[NPIN-1];
   assign cst_s  = ~pins_s[NPIN-2];
   assign cs_s   = ~pins_s[NPIN-3];
   assign rd_s   = ~pins_s[NPIN-4];
   assign wr_s   = ~pins_s[NPIN-5];
   assign wm_s   = pins_s[NPIN-6];
   assign din_s  = pins_s[RES_W-1:0];

   // Read data formatting shared by every read cycle
   function automatic logic [RES_W-1:0] read_word(
      input logic              wm,
      input logic              hb,
      input logic [RES_W-1:0]  res,
      input logic [CHAN_W-1:0] ch
   );
      logic [RES_W-1:0] w;
      w = '0;
      if (wm) begin
         w = res;
      end else if (hb) begin
         w[NIB_W-1:0]          = res[RES_W-1:BYTE_W];
         w[NIB_W+CHAN_W-1:NIB_W] = ch;
      end else begin
         w[BYTE_W-1:0] = res[BYTE_W-1:0];
      end
      return w;
   endfunction

   // Drive mask: byte mode keeps bits 8 and up as inputs
   function automatic logic [RES_W-1:0] drive_mask(input logic wm);
      return wm ? {RES_W{1'b1}} : {{(RES_W-BYTE_W){1'b0}}, {BYTE_W{1'b1}}};
   endfunction

   // Next-state logic
   always_comb begin
      logic mclk_rise;
      logic cst_fall;
      logic cst_rise;
      logic rd_act;
      logic wr_fall;
      mclk_rise = 1'b0;
      cst_fall  = 1'b0;
      cst_rise  = 1'b0;
      rd_act    = 1'b0;
      wr_fall   = 1'b0;
      r_d       = r_q;
      r_d.mclk_prev = mclk_s;
      r_d.cst_prev  = cst_s;
      r_d.rd_prev   = rd_s;
      r_d.wr_prev   = wr_s;
      r_d.wstb      = 1'b0;
      r_d.pwr       = 1'b0;
      mclk_rise = mclk_s & ~r_q.mclk_prev;
      cst_fall  = ~cst_s & r_q.cst_prev;
      cst_rise  = cst_s & ~r_q.cst_prev;

      // [R8] Wake on start rise
      if (cst_rise && low_power_mode) begin
         r_d.pwr = 1'b1;
      end

      // Conversion sequencer; edges counted only when the master clock moves,
      // so a burst clock simply pauses the count
      // [R6] Burst clock tolerated
      unique case (r_q.st)
         ST_TRACK: begin
            // [R7] Hold and start
            if (cst_fall) begin
               r_d.st    = ST_CONVERT;
               r_d.track = 1'b0;
               // [R2] Busy raised
               r_d.busy  = 1'b1;
               r_d.edges = '0;
            end
         end
         ST_CONVERT: begin
            // [R5] Count master edges
            if (mclk_rise) begin
               r_d.edges = r_q.edges + CNT_W'(1);
               if (r_q.edges == CNT_W'(CONV_N - 1)) begin
                  // [R4] Back to track
                  r_d.track = 1'b1;
                  r_d.st    = ST_TAIL;
                  r_d.tail  = CNT_W'(TAIL_CYCLES);
               end
            end
         end
         ST_TAIL: begin
            if (r_q.tail == CNT_W'(1)) begin
               // [R3] Load result and drop busy on the same edge
               r_d.result = sar_result;
               r_d.chan   = sar_channel;
               r_d.busy   = 1'b0;
               r_d.st     = ST_TRACK;
            end else begin
               r_d.tail = r_q.tail - CNT_W'(1);
            end
         end
      endcase

      // [R11] Strobes count only with select low
      rd_act  = ~cs_s & ~rd_s;
      wr_fall = ~cs_s & ~wr_s & r_q.wr_prev;

      // [R10] Result onto bus during read
      // [R12] Half chosen by high byte select
      // [R13] Channel id in high byte
      // [R15] Width by word/byte select
      if (rd_act) begin
         r_d.dout = read_word(wm_s, din_s[HBS_BIT], r_q.result, r_q.chan);
         // [R1] Gated three-state drive
         r_d.oe   = drive_mask(wm_s);
      end else begin
         // [R16] Released otherwise
         r_d.oe   = '0;
         r_d.dout = '0;
      end

      // [R9] Capture write data
      // [R14] High nibble assumed zero from host, not checked
      if (wr_fall) begin
         r_d.wstb  = 1'b1;
         r_d.whigh = ~wm_s & din_s[HBS_BIT];
         r_d.wdata = wm_s ? din_s : {{(RES_W-BYTE_W){1'b0}}, din_s[BYTE_W-1:0]};
      end
   end

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_q           <= '0;
         r_q.st        <= ST_TRACK;
         r_q.track     <= 1'b1;
         r_q.mclk_prev <= 1'b0;
         r_q.cst_prev  <= 1'b1;
         r_q.rd_prev   <= 1'b1;
         r_q.wr_prev   <= 1'b1;
         r_q.result    <= RESULT_RST;
         r_q.chan      <= CHAN_RST;
         r_q.wdata     <= WREG_RST;
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs straight from flops
   assign busy         = r_q.busy;
   assign track_mode   = r_q.track;
   assign power_up     = r_q.pwr;
   assign data_out     = r_q.dout;
   assign data_oe      = r_q.oe;
   assign wr_data      = r_q.wdata;
   assign wr_strobe    = r_q.wstb;
   assign wr_high_byte = r_q.whigh;
endmodule

// >>> verification/apc_host_model.sv
// Host-side burst source for the master conversion clock
`timescale 1ns/1ps
module apc_host_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Device status, pace and clock pin
   input  wire logic       busy,
   input  wire logic [1:0] half,
   output logic            master_conv_clock
);
   logic [1:0] ph_q;
   // Burst only while busy; stands low between frames
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_q <= 2'h0;
         master_conv_clock <= 1'b0;
      end else if (busy || master_conv_clock) begin
         ph_q <= (ph_q == half) ? 2'h0 : ph_q + 2'h1;
         if (ph_q == half) master_conv_clock <= ~master_conv_clock;
      end else begin
         ph_q <= 2'h0;
      end
   end
endmodule

// >>> verification/apc_ctrl_checker.sv
// Port checks for the conversion-control block
`timescale 1ns/1ps
module apc_ctrl_checker
   import apc_pkg::*;
(
   // Clock, reset, pins
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             busy,
   input  wire logic             track_mode,
   input  wire logic             cs_n,
   input  wire logic             rd_n,
   input  wire logic             wr_n,
   input  wire logic             word_mode,
   input  wire logic [RES_W-1:0] data_out,
   input  wire logic [RES_W-1:0] data_oe,
   input  wire logic             wr_strobe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_busy_enters_hold: assert property ($rose(busy) |-> !track_mode)
      else $error("busy rose while tracking");
   a_track_then_done: assert property ($rose(track_mode) |-> busy ##[1:2] !busy)
      else $error("busy did not fall after track");
   a_conv_min_len: assert property ($rose(busy) |-> busy[*8])
      else $error("conversion too short");
   a_read_gated: assert property (data_oe != 12'h000 |-> !$past(cs_n, 3) && !$past(rd_n, 3))
      else $error("bus driven without read");
   a_word_width: assert property (data_oe != 12'h000 && word_mode |-> data_oe == 12'hFFF)
      else $error("word read width wrong");
   a_byte_width: assert property (data_oe != 12'h000 && !word_mode |-> data_oe == 12'h0FF)
      else $error("byte read width wrong");
   a_idle_zero: assert property (data_oe == 12'h000 |-> data_out == 12'h000)
      else $error("data seen while released");
   a_write_gated: assert property (wr_strobe |-> !$past(cs_n, 2) && !$past(wr_n, 2))
      else $error("write without select");
   c_conv: cover property ($rose(busy));
   c_write: cover property (wr_strobe);
   c_byte: cover property (data_oe == 12'h0FF);
endmodule
bind apc_ctrl apc_ctrl_checker apc_ctrl_checker_i (.clk(clk), .arst_n(arst_n), .busy(busy),
   .track_mode(track_mode), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .word_mode(word_mode),
   .data_out(data_out), .data_oe(data_oe), .wr_strobe(wr_strobe));

// >>> verification/apc_ctrl_tb_top.sv
// Self-checking bench for the conversion-control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module apc_ctrl_tb_top;
   import apc_pkg::*;
   logic             clk = 1'b0, arst_n = 1'b0, start_n = 1'b1, lp = 1'b0;
   logic             cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, wm = 1'b1;
   logic [1:0]       half = 2'h2;
   logic [RES_W-1:0] din = 12'h000, dout, doe, wdata;
   logic             mclk, busy, track, pup, wstb, whb;
   int               err_total = 0, cmp_count = 0;
   apc_ctrl apc_ctrl_i (.clk(clk), .arst_n(arst_n), .master_conv_clock(mclk),
      .conversion_start_n(start_n), .busy(busy), .track_mode(track), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .word_mode(wm), .data_in(din), .data_out(dout),
      .data_oe(doe), .sar_result(12'hA5C), .sar_channel(3'h5), .low_power_mode(lp),
      .power_up(pup), .wr_data(wdata), .wr_strobe(wstb), .wr_high_byte(whb));
   apc_host_model apc_host_model_i (.clk(clk), .arst_n(arst_n), .busy(busy), .half(half),
      .master_conv_clock(mclk));
   initial forever #10 clk = ~clk;
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Conversion; a start inside it is refused (driven only with low_pwr clear), edges and wake pulses counted
   task automatic conv_test(logic low_pwr);
      int r = 0, w = 0, n = 0;
      logic p = 1'b0;
      lp = low_pwr;
      start_n = 1'b0;
      while (!busy && n < 20) begin step(1); n++; end
      if (!busy) begin err_total++; close_out(); end
      start_n = 1'b1;
      while (busy && n < 400) begin
         if (!low_pwr && n == 30) start_n = 1'b0;
         if (n == 34) start_n = 1'b1;
         step(1);
         n++;
         if (mclk && !p) r++;
         if (pup) w++;
         p = mclk;
      end
      if (n >= 400) begin err_total++; close_out(); end
      step(4);
      `CHK("master edges", CONV_EDGES, r)
      `CHK("tracking", 1'b1, track)
      `CHK("no restart", 1'b0, busy)
      `CHK("wake pulses", int'(low_pwr), w)
   endtask
   // Read, then release
   task automatic rd_test(logic s_n, logic w, logic hb, logic [RES_W-1:0] e_oe, e_d);
      wm = w;
      din = {3'h0, hb, 8'h00};
      cs_n = s_n;
      rd_n = 1'b0;
      step(4);
      `CHK("read enable", e_oe, doe)
      `CHK("read data", e_d, dout)
      rd_n = 1'b1;
      cs_n = 1'b1;
      step(4);
      `CHK("bus release", 12'h000, doe)
   endtask
   // Write; a deselected write leaves captured data alone
   task automatic wr_test(logic s_n, logic w, logic [RES_W-1:0] d, m, e, logic e_hb);
      int s = 0;
      wm = w;
      din = d;
      cs_n = s_n;
      wr_n = 1'b0;
      repeat (5) begin step(1); if (wstb) s++; end
      wr_n = 1'b1;
      cs_n = 1'b1;
      step(2);
      `CHK("write data", e, wdata & m)
      `CHK("write half", e_hb, whb)
      `CHK("write count", int'(!s_n), s)
   endtask
   initial begin
      step(4);
      arst_n = 1'b1;
      step(4);
      conv_test(1'b0);
      half = 2'h3;
      conv_test(1'b1);
      rd_test(1'b0, 1'b1, 1'b0, 12'hFFF, 12'hA5C);
      rd_test(1'b0, 1'b0, 1'b0, 12'h0FF, 12'h05C);
      rd_test(1'b0, 1'b0, 1'b1, 12'h0FF, 12'h05A);
      rd_test(1'b1, 1'b1, 1'b0, 12'h000, 12'h000);
      wr_test(1'b0, 1'b1, 12'h3C5, 12'hFFF, 12'h3C5, 1'b0);
      wr_test(1'b1, 1'b1, 12'h0AA, 12'hFFF, 12'h3C5, 1'b0);
      // High byte written with bits 7:4 zero
      wr_test(1'b0, 1'b0, 12'h107, 12'h0FF, 12'h007, 1'b1);
      wr_test(1'b0, 1'b0, 12'h0E4, 12'h0FF, 12'h0E4, 1'b0);
      close_out();
   end
endmodule
